//--- shared/tasb_if.sv
// serial clock and shared data line joining the channel and its peer
`timescale 1ns/1ps
interface tasb_if;
  logic dev_sck_o;
  logic dev_sck_oe;
  logic dev_sda_o;
  logic dev_sda_oe;
  logic peer_sck_o;
  logic peer_sck_oe;
  logic peer_sda_o;
  logic peer_sda_oe;
  logic sck;
  logic sda;

  // undriven clock idles high; data line is wired-and with a pull-up
  assign sck = dev_sck_oe ? dev_sck_o : (peer_sck_oe ? peer_sck_o : 1'b1);
  assign sda = ~((dev_sda_oe & ~dev_sda_o) | (peer_sda_oe & ~peer_sda_o));

  modport dev (
    input  sck,
    input  sda,
    output dev_sck_o,
    output dev_sck_oe,
    output dev_sda_o,
    output dev_sda_oe
  );

  modport peer (
    input  sck,
    input  sda,
    output peer_sck_o,
    output peer_sck_oe,
    output peer_sda_o,
    output peer_sda_oe
  );
endinterface

//--- shared/tasb_pkg.sv
// constants, register map and state codes for the two-wire addressed serial bus
package tasb_pkg;

  // system clock and serial clock timing
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned SCK_HALF_NS   = 320;
  localparam int unsigned SCK_HALF_CYC  = (SCK_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // wishbone register map (byte addresses)
  localparam int unsigned WB_AW          = 4;
  localparam logic [3:0]  REG_SHIFT      = 4'h0;
  localparam logic [3:0]  REG_SLAVE_ADDR = 4'h4;
  localparam logic [3:0]  REG_MODE       = 4'h8;
  localparam logic [3:0]  REG_STATUS     = 4'hC;

  // serial mode register fields
  localparam int unsigned MODE_ENABLE    = 0;
  localparam int unsigned MODE_MASTER    = 1;
  localparam int unsigned MODE_WAKEUP    = 2;
  localparam int unsigned MODE_REL_IRQ   = 3;
  localparam int unsigned MODE_BUSY_HOLD = 4;
  localparam int unsigned MODE_REL_GO    = 6;
  localparam int unsigned MODE_CMD_GO    = 7;

  // status register fields
  localparam int unsigned STAT_DONE      = 0;
  localparam int unsigned STAT_REL       = 1;
  localparam int unsigned STAT_CMD       = 2;
  localparam int unsigned STAT_ACK       = 3;
  localparam int unsigned STAT_MATCH     = 4;
  localparam int unsigned STAT_BUSY      = 5;

  // reset values and byte framing
  localparam logic [7:0]  SHIFT_RESET    = 8'hFF;
  localparam logic [7:0]  SLAVE_ADDR_RST = 8'h00;
  localparam logic [3:0]  BIT_LAST       = 4'h8;
  localparam logic [1:0]  CTL_LAST_STEP  = 2'h3;

  typedef enum logic [4:0] {
    ST_IDLE = 5'b00001,
    ST_WAIT = 5'b00010,
    ST_LOW  = 5'b00100,
    ST_HIGH = 5'b01000,
    ST_CTL  = 5'b10000
  } tasb_state_t;

  typedef enum logic [1:0] {
    KIND_DATA = 2'h0,
    KIND_CMD  = 2'h1,
    KIND_ADDR = 2'h2
  } tasb_kind_t;

endpackage

//--- sim/tasb_chk.sv
// interface checker for the two-wire bus joining channel and peer
`timescale 1ns/1ps
module tasb_chk #(
  parameter int unsigned HALF_CYC = tasb_pkg::SCK_HALF_CYC
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic dev_sck_o,
  input wire logic dev_sck_oe,
  input wire logic dev_sda_o,
  input wire logic dev_sda_oe,
  input wire logic peer_sck_o,
  input wire logic peer_sck_oe,
  input wire logic peer_sda_o,
  input wire logic peer_sda_oe,
  input wire logic sck,
  input wire logic sda
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  // cycles since the peer clock value last moved; wide so long ready waits do not wrap
  logic [15:0] hold_r;
  always_ff @(posedge clk_i) begin
    hold_r <= (rst_i || $changed(peer_sck_o)) ? 16'h0000 : hold_r + 16'h0001;
  end

  a_dev_open_drain:  assert property (dev_sda_oe |-> !dev_sda_o) else $error("channel drives data high");
  a_peer_open_drain: assert property (peer_sda_oe |-> !peer_sda_o) else $error("peer drives data high");
  a_slave_no_sck:    assert property (!dev_sck_oe) else $error("slave channel drives clock");
  a_sck_half_period: assert property (peer_sck_oe && $past(peer_sck_oe) && $changed(peer_sck_o)
    |-> hold_r >= HALF_CYC - 1) else $error("clock phase too short");
  // only short high phases count: a long wait with the clock high is where busy hold ends
  a_data_held_high:  assert property (peer_sck_oe && sck && $past(sck) && $past(sck, 2)
    && hold_r <= 16'(2 * HALF_CYC)
    |-> $stable(dev_sda_oe)) else $error("channel moved data while clock high");
  // a fall after a long high phase leaves a ready wait; the line was read two edges earlier
  a_ready_before_go: assert property ($fell(peer_sck_o) && hold_r > 16'(HALF_CYC)
    |-> !$past(dev_sda_oe, 2) || peer_sda_oe)
    else $error("clocking started while line busy");
  a_frame_ends_high: assert property ($fell(peer_sck_oe) |-> $past(peer_sck_o))
    else $error("frame left clock low");
  a_reset_released:  assert property ($fell(rst_i) |-> !dev_sda_oe && !peer_sda_oe && !peer_sck_oe)
    else $error("pins driven after reset");

  c_frame: cover property ($rose(peer_sck_oe));
  c_dev_drives: cover property ($rose(dev_sda_oe));
  c_control: cover property (sck && $past(sck) && $fell(sda));
endmodule

//--- sim/tb.sv
// testbench: channel as slave, peer as master, both on one bus
`timescale 1ns/1ps
module tb;
  import tasb_pkg::*;
  localparam int unsigned HALF = 8;
  localparam logic [31:0] M_EN = 32'h0000_0001;
  localparam logic [31:0] M_WU = 32'h0000_0004;
  localparam logic [31:0] M_RI = 32'h0000_0008;
  localparam logic [31:0] M_BH = 32'h0000_0010;
  localparam logic [31:0] W1C  = 32'h0000_000F;
  logic        clk_i  = 1'b0;
  logic        rst_i  = 1'b1;
  logic        wb_cyc = 1'b0;
  logic        wb_stb = 1'b0;
  logic        wb_we  = 1'b0;
  logic [3:0]  wb_adr = 4'h0;
  logic [31:0] wb_dat = 32'h0000_0000;
  logic [31:0] wb_rdat;
  logic        wb_ack;
  logic        p_start = 1'b0;
  tasb_kind_t  p_kind  = KIND_DATA;
  logic [7:0]  p_tx    = 8'h00;
  logic        p_busy;
  logic        p_done;
  logic [7:0]  p_rx;
  logic        p_ack;
  logic [31:0] q;
  int          fails;
  int          samples_checked;
  int          done_seen = 0;

  always #5 clk_i = ~clk_i;

  // every finished peer byte gives one done pulse
  always @(posedge clk_i) begin
    if (p_done === 1'b1) begin
      done_seen <= done_seen + 1;
    end
  end

  tasb_if link_a ();
  tasb_dev #(.HALF_CYC(HALF)) u_tasb_dev (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc),
    .wb_stb_i(wb_stb), .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(4'h1), .wb_dat_i(wb_dat),
    .wb_dat_o(wb_rdat), .wb_ack_o(wb_ack), .link(link_a));
  tasb_peer #(.HALF_CYC(HALF)) u_tasb_peer (.clk_i(clk_i), .rst_i(rst_i), .start_i(p_start),
    .kind_i(p_kind), .tx_byte_i(p_tx), .busy_o(p_busy), .done_o(p_done), .rx_byte_o(p_rx),
    .ack_o(p_ack), .link(link_a));
  tasb_chk #(.HALF_CYC(HALF)) u_tasb_chk (.clk_i(clk_i), .rst_i(rst_i), .dev_sck_o(link_a.dev_sck_o),
    .dev_sck_oe(link_a.dev_sck_oe), .dev_sda_o(link_a.dev_sda_o), .dev_sda_oe(link_a.dev_sda_oe),
    .peer_sck_o(link_a.peer_sck_o), .peer_sck_oe(link_a.peer_sck_oe), .peer_sda_o(link_a.peer_sda_o),
    .peer_sda_oe(link_a.peer_sda_oe), .sck(link_a.sck), .sda(link_a.sda));

  task automatic end_sim;
    $display("comparisons %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // classic single cycle; the answer is taken at the edge that samples ack
  task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d, output logic [31:0] r);
    int n;
    @(posedge clk_i);
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we  <= w;
    wb_adr <= a;
    wb_dat <= d;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack !== 1'b1 && n < 20);
    r = wb_rdat;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    if (n >= 20) begin
      fails++;
      end_sim;
    end
  endtask

  // peer busy rises the cycle after the start pulse, so wait one edge before polling it
  task automatic peer(input tasb_kind_t k, input logic [7:0] b);
    int n;
    @(posedge clk_i);
    p_start <= 1'b1;
    p_kind  <= k;
    p_tx    <= b;
    @(posedge clk_i);
    p_start <= 1'b0;
    @(posedge clk_i);
    n = 0;
    while (p_busy !== 1'b0 && n < 5000) begin
      @(posedge clk_i);
      n++;
    end
    if (n >= 5000) begin
      fails++;
      end_sim;
    end
  endtask

  task automatic tend(input string nm);
    $display("test %s finished, mismatches so far %0d", nm, fails);
  endtask

  initial begin
    fails = 0;
    samples_checked = 0;
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    wb(1'b1, REG_SHIFT, 32'h0000_0012, q);
    wb(1'b0, REG_SHIFT, 32'h0000_0000, q);
    check("shift_disabled", q, 32'h0000_00FF);
    wb(1'b0, 4'h2, 32'h0000_0000, q);
    check("unmapped", q, 32'h0000_0000);
    wb(1'b0, REG_STATUS, 32'h0000_0000, q);
    check("status_reset", q, 32'h0000_0000);
    tend("reset");
    wb(1'b1, REG_MODE, M_EN, q);
    wb(1'b1, REG_SHIFT, 32'h0000_00FF, q);
    peer(KIND_DATA, 8'hA5);
    wb(1'b0, REG_SHIFT, 32'h0000_0000, q);
    check("rx_byte", q, 32'h0000_00A5);
    wb(1'b0, REG_STATUS, 32'h0000_0000, q);
    check("done_flag", q & W1C, 32'h0000_0001);
    check("peer_ack", {31'h0, p_ack}, 32'h0000_0000);
    wb(1'b1, REG_STATUS, W1C, q);
    tend("receive");
    wb(1'b1, REG_SHIFT, 32'h0000_003C, q);
    peer(KIND_DATA, 8'hFF);
    check("peer_rx", {24'h0, p_rx}, 32'h0000_003C);
    wb(1'b0, REG_SHIFT, 32'h0000_0000, q);
    check("shift_captured", q, 32'h0000_003C);
    tend("transmit");
    wb(1'b1, REG_MODE, M_EN | M_BH, q);
    fork
      peer(KIND_DATA, 8'hFF);
      begin
        repeat (100) @(posedge clk_i);
        check("held_clock", {30'h0, p_busy, link_a.sck}, 32'h0000_0003);
        wb(1'b1, REG_MODE, M_EN, q);
      end
    join
    check("after_ready", {24'h0, p_rx}, 32'h0000_00FF);
    tend("busy_hold");
    wb(1'b1, REG_SLAVE_ADDR, 32'h0000_005A, q);
    wb(1'b1, REG_MODE, M_EN | M_WU, q);
    wb(1'b1, REG_STATUS, W1C, q);
    peer(KIND_ADDR, 8'h33);
    wb(1'b0, REG_STATUS, 32'h0000_0000, q);
    check("mismatch", q & 32'h0000_0003, 32'h0000_0000);
    peer(KIND_ADDR, 8'h5A);
    wb(1'b0, REG_STATUS, 32'h0000_0000, q);
    check("match", q & 32'h0000_0013, 32'h0000_0013);
    wb(1'b1, REG_STATUS, W1C, q);
    wb(1'b1, REG_SHIFT, 32'h0000_0000, q);
    peer(KIND_DATA, 8'hFF);
    check("wakeup_released", {24'h0, p_rx}, 32'h0000_00FF);
    wb(1'b0, REG_STATUS, 32'h0000_0000, q);
    check("data_no_flag", q & 32'h0000_0001, 32'h0000_0000);
    tend("wakeup");
    wb(1'b1, REG_MODE, M_EN | M_WU | M_RI, q);
    wb(1'b1, REG_STATUS, W1C, q);
    peer(KIND_ADDR, 8'h33);
    wb(1'b0, REG_STATUS, 32'h0000_0000, q);
    check("release_irq", q & 32'h0000_0003, 32'h0000_0003);
    tend("release_irq");
    wb(1'b1, REG_MODE, M_EN, q);
    wb(1'b1, REG_STATUS, W1C, q);
    wb(1'b1, REG_SHIFT, 32'h0000_00FF, q);
    peer(KIND_CMD, 8'h77);
    wb(1'b0, REG_STATUS, 32'h0000_0000, q);
    check("command", q & 32'h0000_0007, 32'h0000_0005);
    wb(1'b0, REG_SHIFT, 32'h0000_0000, q);
    check("command_byte", q, 32'h0000_0077);
    check("peer_done_count", done_seen, 32'h0000_0008);
    tend("command");
    end_sim;
  end
endmodule

//--- verilog/tasb_dev.sv
// serial channel in addressed two-wire bus mode with a wishbone register port
//
// The register addresses and the Wishbone interface to the registers were left to the implementer.
`timescale 1ns/1ps
module tasb_dev #(
  parameter int unsigned HALF_CYC = tasb_pkg::SCK_HALF_CYC,
  parameter int unsigned AW       = tasb_pkg::WB_AW
) (
  input  wire logic          clk_i,
  input  wire logic          rst_i,
  input  wire logic          wb_cyc_i,
  input  wire logic          wb_stb_i,
  input  wire logic          wb_we_i,
  input  wire logic [AW-1:0] wb_adr_i,
  input  wire logic [3:0]    wb_sel_i,
  input  wire logic [31:0]   wb_dat_i,
  output logic      [31:0]   wb_dat_o,
  output logic               wb_ack_o,
  tasb_if.dev                link
);
  import tasb_pkg::*;

  if (HALF_CYC < 2 || HALF_CYC > 65535 || AW < 4) begin : g_param_chk
    $error("tasb_dev: unsupported parameter value");
  end

  logic        sck_s1_r, sck_s_r, sck_d_r;
  logic        sda_s1_r, sda_s_r, sda_d_r;
  logic        en_r, master_r, wup_r, sic_r, busy_hold_r;
  logic [7:0]  sva_r;
  logic [7:0]  shreg_r;
  logic        tx_bit_r;
  logic        armed_r;
  logic [3:0]  bit_cnt_r;
  logic        addr_phase_r;
  logic        done_f_r, rel_f_r, cmd_f_r, ack_f_r;
  tasb_state_t state_r;
  logic [15:0] div_r;
  logic [1:0]  ctl_step_r;
  logic        ctl_rel_r;
  logic        ctl_pull_r;
  logic        sck_o_r, sck_oe_r, sda_oe_r;
  logic [31:0] dat_r;
  logic        ack_r;

  // pin synchronisers; only the second stage and later are used
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sck_s1_r <= 1'b1;
      sck_s_r  <= 1'b1;
      sck_d_r  <= 1'b1;
      sda_s1_r <= 1'b1;
      sda_s_r  <= 1'b1;
      sda_d_r  <= 1'b1;
    end else begin
      sck_s1_r <= link.sck;
      sck_s_r  <= sck_s1_r;
      sck_d_r  <= sck_s_r;
      sda_s1_r <= link.sda;
      sda_s_r  <= sda_s1_r;
      sda_d_r  <= sda_s_r;
    end
  end

  // bus decode
  logic wb_req, wr, wr_shift, wr_sva, wr_mode, wr_stat;
  assign wb_req   = wb_cyc_i & wb_stb_i & ~ack_r;
  assign wr       = wb_req & wb_we_i & wb_sel_i[0];
  assign wr_shift = wr & (wb_adr_i == AW'(REG_SHIFT));
  assign wr_sva   = wr & (wb_adr_i == AW'(REG_SLAVE_ADDR));
  assign wr_mode  = wr & (wb_adr_i == AW'(REG_MODE));
  assign wr_stat  = wr & (wb_adr_i == AW'(REG_STATUS));

  // bus events and control signals
  logic tick, ready, fall_ev, rise_ev, rise9, rel_ev, cmd_ev;
  logic start_ok, start, go_rel, go_cmd, match, wake_mode, done_set, rel_clr_hw, busy;
  assign tick      = div_r == 16'(HALF_CYC - 1);
  assign ready     = sda_s_r | ctl_pull_r;
  assign fall_ev   = en_r & (master_r ? ((state_r == ST_WAIT) & ready) |
                                        ((state_r == ST_HIGH) & tick & (bit_cnt_r != 4'h0))
                                      : (sck_d_r & ~sck_s_r));
  assign rise_ev   = en_r & (master_r ? ((state_r == ST_LOW) & tick) : (~sck_d_r & sck_s_r));
  assign rise9     = rise_ev & (bit_cnt_r == BIT_LAST);
  assign rel_ev    = en_r & sck_s_r & sck_d_r & sda_s_r & ~sda_d_r;
  assign cmd_ev    = en_r & sck_s_r & sck_d_r & ~sda_s_r & sda_d_r;
  assign start_ok  = en_r & (master_r ? (state_r == ST_IDLE)
                                      : ((bit_cnt_r == 4'h0) & sck_s_r));
  assign start     = wr_shift & start_ok;
  assign go_rel    = wr_mode & wb_dat_i[MODE_REL_GO] & en_r & master_r & (state_r == ST_IDLE);
  assign go_cmd    = wr_mode & wb_dat_i[MODE_CMD_GO] & en_r & master_r & (state_r == ST_IDLE) & ~go_rel;
  assign match     = shreg_r == sva_r;
  assign wake_mode = wup_r & ~sic_r;
  assign done_set  = (rise9 & (~wake_mode | (addr_phase_r & match))) | (rel_ev & sic_r);
  assign rel_clr_hw = rise9 & wake_mode & addr_phase_r & ~match;
  assign busy      = master_r ? (state_r != ST_IDLE) : (armed_r | (bit_cnt_r != 4'h0));

  // mode and slave address registers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      en_r        <= 1'b0;
      master_r    <= 1'b0;
      wup_r       <= 1'b0;
      sic_r       <= 1'b0;
      busy_hold_r <= 1'b0;
      sva_r       <= SLAVE_ADDR_RST;
    end else begin
      if (wr_mode) begin
        en_r        <= wb_dat_i[MODE_ENABLE];
        master_r    <= wb_dat_i[MODE_MASTER];
        wup_r       <= wb_dat_i[MODE_WAKEUP];
        sic_r       <= wb_dat_i[MODE_REL_IRQ];
        busy_hold_r <= wb_dat_i[MODE_BUSY_HOLD];
      end
      if (wr_sva) begin
        sva_r <= wb_dat_i[7:0];
      end
    end
  end

  // master clock generator and release/command sequencer
  always_ff @(posedge clk_i) begin
    if (rst_i || !en_r || !master_r) begin
      state_r    <= ST_IDLE;
      div_r      <= 16'h0000;
      sck_o_r    <= 1'b1;
      ctl_step_r <= 2'h0;
      ctl_rel_r  <= 1'b0;
    end else begin
      div_r <= (tick || state_r == ST_IDLE || state_r == ST_WAIT) ? 16'h0000 : div_r + 16'h0001;
      unique case (state_r)
        ST_IDLE: begin
          if (start) begin
            state_r <= ST_WAIT;
          end else if (go_rel || go_cmd) begin
            state_r    <= ST_CTL;
            sck_o_r    <= 1'b0;
            ctl_step_r <= 2'h0;
            ctl_rel_r  <= go_rel;
          end
        end
        ST_WAIT: begin
          if (ready) begin
            state_r <= ST_LOW;
            sck_o_r <= 1'b0;
          end
        end
        ST_LOW: begin
          if (tick) begin
            state_r <= ST_HIGH;
            sck_o_r <= 1'b1;
          end
        end
        ST_HIGH: begin
          if (tick) begin
            // bit counter already wrapped after the ninth clock: stop with clock high
            state_r <= (bit_cnt_r != 4'h0) ? ST_LOW : ST_IDLE;
            sck_o_r <= (bit_cnt_r == 4'h0);
          end
        end
        ST_CTL: begin
          if (tick) begin
            ctl_step_r <= ctl_step_r + 2'h1;
            if (ctl_step_r == 2'h1) begin
              sck_o_r <= 1'b1;
            end
            if (ctl_step_r == CTL_LAST_STEP) begin
              state_r <= ST_IDLE;
            end
          end
        end
      endcase
    end
  end

  // data line hold during control signals; set up with the clock low, the signalling edge while it is high
  always_ff @(posedge clk_i) begin
    if (rst_i || !en_r) begin
      ctl_pull_r <= 1'b0;
    end else if (state_r == ST_CTL && tick && ctl_step_r == 2'h0) begin
      ctl_pull_r <= ctl_rel_r;
    end else if (state_r == ST_CTL && tick && ctl_step_r == 2'h2) begin
      ctl_pull_r <= ~ctl_rel_r;
    end else if (fall_ev) begin
      ctl_pull_r <= 1'b0;
    end
  end

  // shift register, output latch and bit counter
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      shreg_r      <= SHIFT_RESET;
      tx_bit_r     <= 1'b1;
      armed_r      <= 1'b0;
      bit_cnt_r    <= 4'h0;
      addr_phase_r <= 1'b0;
    end else if (!en_r) begin
      tx_bit_r     <= 1'b1;
      armed_r      <= 1'b0;
      bit_cnt_r    <= 4'h0;
      addr_phase_r <= 1'b0;
    end else begin
      if (rel_ev || cmd_ev) begin
        bit_cnt_r    <= 4'h0;
        // the command that follows a release must not end the address phase
        addr_phase_r <= rel_ev | addr_phase_r;
      end else if (fall_ev) begin
        tx_bit_r <= (bit_cnt_r < BIT_LAST) ? shreg_r[7] : 1'b1;
      end else if (rise_ev) begin
        if (bit_cnt_r != BIT_LAST) begin
          shreg_r   <= {shreg_r[6:0], sda_s_r};
          bit_cnt_r <= bit_cnt_r + 4'h1;
        end else begin
          bit_cnt_r    <= 4'h0;
          armed_r      <= 1'b0;
          addr_phase_r <= 1'b0;
        end
      end
      if (start) begin
        shreg_r  <= wb_dat_i[7:0];
        armed_r  <= 1'b1;
        tx_bit_r <= 1'b1;
      end
    end
  end

  // status flags; a hardware set wins over a software clear
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      done_f_r <= 1'b0;
      rel_f_r  <= 1'b0;
      cmd_f_r  <= 1'b0;
      ack_f_r  <= 1'b0;
    end else begin
      done_f_r <= done_set | (done_f_r & ~(wr_stat & wb_dat_i[STAT_DONE]));
      rel_f_r  <= rel_ev | (rel_f_r & ~(wr_stat & wb_dat_i[STAT_REL]) & ~rel_clr_hw & en_r);
      cmd_f_r  <= cmd_ev | (cmd_f_r & ~(wr_stat & wb_dat_i[STAT_CMD]) & ~rel_ev & en_r);
      ack_f_r  <= (rise9 & ~sda_s_r) | (ack_f_r & ~(wr_stat & wb_dat_i[STAT_ACK]) & ~start & en_r);
    end
  end

  // pin drivers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sck_oe_r <= 1'b0;
      sda_oe_r <= 1'b0;
    end else begin
      sck_oe_r <= en_r & master_r;
      // open drain: only ever pulls low, never drives a high level
      sda_oe_r <= en_r & ((armed_r & ~wup_r & ~tx_bit_r) | ctl_pull_r | (busy_hold_r & ~master_r));
    end
  end

  assign link.dev_sck_o  = sck_o_r;
  assign link.dev_sck_oe = sck_oe_r;
  assign link.dev_sda_o  = 1'b0;
  assign link.dev_sda_oe = sda_oe_r;

  // wishbone answer one cycle after the request, unmapped reads as zero
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_r <= 1'b0;
      dat_r <= 32'h0000_0000;
    end else begin
      ack_r <= wb_req;
      dat_r <= 32'h0000_0000;
      if (wb_req && !wb_we_i) begin
        unique case (wb_adr_i)
          AW'(REG_SHIFT):      dat_r[7:0] <= shreg_r;
          AW'(REG_SLAVE_ADDR): dat_r[7:0] <= sva_r;
          AW'(REG_MODE): begin
            dat_r[MODE_ENABLE]    <= en_r;
            dat_r[MODE_MASTER]    <= master_r;
            dat_r[MODE_WAKEUP]    <= wup_r;
            dat_r[MODE_REL_IRQ]   <= sic_r;
            dat_r[MODE_BUSY_HOLD] <= busy_hold_r;
          end
          AW'(REG_STATUS): begin
            dat_r[STAT_DONE]  <= done_f_r;
            dat_r[STAT_REL]   <= rel_f_r;
            dat_r[STAT_CMD]   <= cmd_f_r;
            dat_r[STAT_ACK]   <= ack_f_r;
            dat_r[STAT_MATCH] <= match;
            dat_r[STAT_BUSY]  <= busy;
          end
          default: dat_r <= 32'h0000_0000;
        endcase
      end
    end
  end

  assign wb_ack_o = ack_r;
  assign wb_dat_o = dat_r;
endmodule

//--- verilog/tasb_peer.sv
// bus master on the far side: clock divider, release/command signals, byte transfers
`timescale 1ns/1ps
module tasb_peer #(
  parameter int unsigned HALF_CYC = tasb_pkg::SCK_HALF_CYC
) (
  input  wire logic                 clk_i,
  input  wire logic                 rst_i,
  input  wire logic                 start_i,
  input  wire tasb_pkg::tasb_kind_t kind_i,
  input  wire logic [7:0]           tx_byte_i,
  output logic                      busy_o,
  output logic                      done_o,
  output logic      [7:0]           rx_byte_o,
  output logic                      ack_o,
  tasb_if.peer                      link
);
  import tasb_pkg::*;

  if (HALF_CYC < 2 || HALF_CYC > 65535) begin : g_param_chk
    $error("tasb_peer: unsupported parameter value");
  end

  logic        sda_s1_r, sda_s_r;
  tasb_state_t state_r;
  logic [15:0] div_r;
  logic [1:0]  ctl_step_r;
  logic        ctl_rel_r, ctl_pull_r;
  logic        need_rel_r, need_cmd_r;
  logic [7:0]  sr_r;
  logic [3:0]  bit_cnt_r;
  logic        tx_bit_r;
  logic        sck_r, sck_oe_r, sda_oe_r;
  logic        busy_r, done_r, ack_r;
  logic [7:0]  rx_r;
  logic        tick, ready;

  assign tick  = div_r == 16'(HALF_CYC - 1);
  assign ready = sda_s_r | ctl_pull_r;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sda_s1_r <= 1'b1;
      sda_s_r  <= 1'b1;
    end else begin
      sda_s1_r <= link.sda;
      sda_s_r  <= sda_s1_r;
    end
  end

  // sequencer: release, command, then the byte with its ninth clock
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_r    <= ST_IDLE;
      div_r      <= 16'h0000;
      ctl_step_r <= 2'h0;
      ctl_rel_r  <= 1'b0;
      ctl_pull_r <= 1'b0;
      need_rel_r <= 1'b0;
      need_cmd_r <= 1'b0;
      sr_r       <= SHIFT_RESET;
      bit_cnt_r  <= 4'h0;
      tx_bit_r   <= 1'b1;
      sck_r      <= 1'b1;
      done_r     <= 1'b0;
      ack_r      <= 1'b0;
      rx_r       <= 8'h00;
    end else begin
      done_r <= 1'b0;
      div_r  <= (tick || state_r == ST_IDLE || state_r == ST_WAIT) ? 16'h0000 : div_r + 16'h0001;
      unique case (state_r)
        ST_IDLE: begin
          if (start_i) begin
            state_r    <= ST_WAIT;
            sr_r       <= tx_byte_i;
            need_rel_r <= (kind_i == KIND_ADDR);
            need_cmd_r <= (kind_i != KIND_DATA);
          end
        end
        ST_WAIT: begin
          if (ready) begin
            sck_r <= 1'b0;
            if (need_rel_r || need_cmd_r) begin
              state_r    <= ST_CTL;
              ctl_step_r <= 2'h0;
              ctl_rel_r  <= need_rel_r;
            end else begin
              state_r    <= ST_LOW;
              tx_bit_r   <= sr_r[7];
              ctl_pull_r <= 1'b0;
            end
          end
        end
        ST_CTL: begin
          if (tick) begin
            ctl_step_r <= ctl_step_r + 2'h1;
            unique case (ctl_step_r)
              2'h0: ctl_pull_r <= ctl_rel_r;
              2'h1: sck_r <= 1'b1;
              2'h2: ctl_pull_r <= ~ctl_rel_r;
              2'h3: begin
                state_r <= ST_WAIT;
                if (ctl_rel_r) begin
                  need_rel_r <= 1'b0;
                end else begin
                  need_cmd_r <= 1'b0;
                end
              end
            endcase
          end
        end
        ST_LOW: begin
          if (tick) begin
            state_r <= ST_HIGH;
            sck_r   <= 1'b1;
            if (bit_cnt_r != BIT_LAST) begin
              sr_r      <= {sr_r[6:0], sda_s_r};
              bit_cnt_r <= bit_cnt_r + 4'h1;
            end else begin
              bit_cnt_r <= 4'h0;
              ack_r     <= ~sda_s_r;
              rx_r      <= sr_r;
              done_r    <= 1'b1;
            end
          end
        end
        ST_HIGH: begin
          if (tick) begin
            if (bit_cnt_r == 4'h0) begin
              state_r <= ST_IDLE;
            end else begin
              state_r  <= ST_LOW;
              sck_r    <= 1'b0;
              tx_bit_r <= (bit_cnt_r < BIT_LAST) ? sr_r[7] : 1'b1;
            end
          end
        end
        default: state_r <= ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sck_oe_r <= 1'b0;
      sda_oe_r <= 1'b0;
      busy_r   <= 1'b0;
    end else begin
      sck_oe_r <= (state_r != ST_IDLE);
      sda_oe_r <= (~tx_bit_r & (state_r != ST_IDLE)) | ctl_pull_r;
      busy_r   <= (state_r != ST_IDLE) | start_i;
    end
  end

  assign link.peer_sck_o  = sck_r;
  assign link.peer_sck_oe = sck_oe_r;
  assign link.peer_sda_o  = 1'b0;
  assign link.peer_sda_oe = sda_oe_r;
  assign busy_o           = busy_r;
  assign done_o           = done_r;
  assign rx_byte_o        = rx_r;
  assign ack_o            = ack_r;
endmodule
